// *** hw/ncoos_pkg.sv ***
`default_nettype none
// ---------------------------------------------------------------
// Shared constants for the oscillator output stage
// ---------------------------------------------------------------
package ncoos_pkg;
    // Register byte addresses
    localparam logic [4:0] CTRL_OFS  = 5'h00;
    localparam logic [4:0] CLKC_OFS  = 5'h04;
    localparam logic [4:0] INC_OFS   = 5'h08;
    localparam logic [4:0] ACC_OFS   = 5'h0c;
    localparam logic [4:0] IREQ_OFS  = 5'h10;
    localparam logic [4:0] IEN_OFS   = 5'h14;
    // Control register fields
    localparam int CTRL_EN_BIT  = 7;
    localparam int CTRL_OUT_BIT = 5;
    localparam int CTRL_POL_BIT = 4;
    localparam int CTRL_PFM_BIT = 0;
    // Clock configuration fields
    localparam int CLKC_PWS_LSB = 5;
    localparam int CLKC_CKS_LSB = 0;
    // Interrupt register fields
    localparam int IREQ_FLAG_BIT = 0;
    localparam int IEN_IE_BIT    = 0;
    localparam int IEN_PERIPHERAL_IRQ_ENABLE_BIT  = 1;
    localparam int IEN_GIE_BIT   = 2;
    // Widths
    localparam int ACC_W = 20;
    localparam int PW_W  = 7;
    // Clock source code of the fast internal oscillator
    localparam logic [1:0] CKS_FAST_OSC = 2'h0;
    // Reset values: every register clears to zero
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [19:0] RST_WORD = 20'h00000;
    // Control fields carried together
    typedef struct packed {
        logic       module_enable;
        logic       output_polarity;
        logic       pulse_mode_select;
        logic [2:0] pulse_width_select;
        logic [1:0] clock_select;
    } ncoos_cfg_t;
    // Interrupt enables carried together
    typedef struct packed {
        logic overflow_irq_enable;
        logic peripheral_irq_enable;
        logic global_irq_enable;
    } ncoos_ien_t;
endpackage
`default_nettype wire

// *** hw/ncoos_top.sv ***
`default_nettype none
module ncoos_top (
    input  wire logic        clock_in,          // Selected input clock
    input  wire logic        rst_in,            // Async reset, high
    input  wire logic [4:0]  avs_address_in,    // Byte address
    input  wire logic        avs_read_in,       // Read request
    input  wire logic        avs_write_in,      // Write request
    input  wire logic [31:0] avs_writedata_in,  // Write data
    input  wire logic [3:0]  avs_byteenable_in, // Byte lanes
    output logic [31:0]      avs_readdata_out,  // Read data
    output logic             avs_waitrequest_out, // Stall
    output logic             nco_out,           // Final output level
    output logic             overflow_interrupt_out, // Gated irq
    output logic [1:0]       clock_select_out,  // To clock mux
    output logic             keep_fast_osc_out  // Fast osc request
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    ncoos_pkg::ncoos_cfg_t cfg_r;     // Control fields
    ncoos_pkg::ncoos_ien_t ien_r;     // Interrupt enables
    logic [19:0]  inc_r;              // Increment value
    logic [19:0]  acc_r;              // Accumulator
    logic [20:0]  sum;                // Accumulator plus carry
    logic         carry;              // Overflow strobe
    logic         flag_r;             // Overflow irq flag
    logic         raw_r;              // Output before polarity
    logic         raw_nxt;            // Next raw output
    logic [6:0]   cnt_r;              // Pulse periods left
    logic [6:0]   width_m1;           // Pulse length minus one
    logic         level_r;            // Final output level
    logic         ack_r;              // Bus answer cycle
    logic [31:0]  rdata_r;            // Read data register
    logic         req;                // Any bus request
    logic         wr_go;              // Write takes effect
    logic         pol_wr;             // Write to polarity bit
    logic         pol_nxt;            // Polarity after write
    logic         pol_flip;           // Polarity is changing
    logic         flag_clr;           // Software clears flag
    logic [7:0]   ctrl_rd;            // Control read view

    // ---------------------------------------------------------------
    // Bus handshake
    // ---------------------------------------------------------------
    // One wait state: read data is built from flops first,
    // so the master always samples registered data.
    assign req   = avs_read_in | avs_write_in;
    assign wr_go = avs_write_in & ack_r;
    assign avs_waitrequest_out = req & ~ack_r;
    assign avs_readdata_out    = rdata_r;

    // Answer flop toggles high for the single accept cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    // Control view: enable, status, polarity, mode
    always_comb begin
        ctrl_rd = ncoos_pkg::RST_BYTE;
        ctrl_rd[ncoos_pkg::CTRL_EN_BIT]  = cfg_r.module_enable;
        ctrl_rd[ncoos_pkg::CTRL_OUT_BIT] = level_r;
        ctrl_rd[ncoos_pkg::CTRL_POL_BIT] = cfg_r.output_polarity;
        ctrl_rd[ncoos_pkg::CTRL_PFM_BIT] = cfg_r.pulse_mode_select;
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_r <= 32'h00000000;
        end else if (avs_read_in & ~ack_r) begin
            rdata_r <= 32'h00000000;
            if (avs_address_in == ncoos_pkg::CTRL_OFS) begin
                rdata_r[7:0] <= ctrl_rd;
            end else if (avs_address_in == ncoos_pkg::CLKC_OFS) begin
                rdata_r[ncoos_pkg::CLKC_PWS_LSB +: 3] <= cfg_r.pulse_width_select;
                rdata_r[ncoos_pkg::CLKC_CKS_LSB +: 2] <= cfg_r.clock_select;
            end else if (avs_address_in == ncoos_pkg::INC_OFS) begin
                rdata_r[19:0] <= inc_r;
            end else if (avs_address_in == ncoos_pkg::ACC_OFS) begin
                rdata_r[19:0] <= acc_r;
            end else if (avs_address_in == ncoos_pkg::IREQ_OFS) begin
                rdata_r[ncoos_pkg::IREQ_FLAG_BIT] <= flag_r;
            end else if (avs_address_in == ncoos_pkg::IEN_OFS) begin
                rdata_r[ncoos_pkg::IEN_IE_BIT]   <= ien_r.overflow_irq_enable;
                rdata_r[ncoos_pkg::IEN_PERIPHERAL_IRQ_ENABLE_BIT] <= ien_r.peripheral_irq_enable;
                rdata_r[ncoos_pkg::IEN_GIE_BIT]  <= ien_r.global_irq_enable;
            end else begin
                // Unmapped: reads as zero
                rdata_r <= 32'h00000000;
            end
        end
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    // Control and clock config, lane 0 only
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_r <= '0;
        end else if (wr_go & avs_byteenable_in[0]) begin
            if (avs_address_in == ncoos_pkg::CTRL_OFS) begin
                cfg_r.module_enable <=
                    avs_writedata_in[ncoos_pkg::CTRL_EN_BIT];
                cfg_r.output_polarity <=
                    avs_writedata_in[ncoos_pkg::CTRL_POL_BIT];
                cfg_r.pulse_mode_select <=
                    avs_writedata_in[ncoos_pkg::CTRL_PFM_BIT];
            end else if (avs_address_in == ncoos_pkg::CLKC_OFS) begin
                cfg_r.pulse_width_select <=
                    avs_writedata_in[ncoos_pkg::CLKC_PWS_LSB +: 3];
                cfg_r.clock_select <=
                    avs_writedata_in[ncoos_pkg::CLKC_CKS_LSB +: 2];
            end
        end
    end

    // Interrupt enables
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ien_r <= '0;
        end else if (wr_go & avs_byteenable_in[0] &
                     (avs_address_in == ncoos_pkg::IEN_OFS)) begin
            ien_r.overflow_irq_enable <=
                avs_writedata_in[ncoos_pkg::IEN_IE_BIT];
            ien_r.peripheral_irq_enable <=
                avs_writedata_in[ncoos_pkg::IEN_PERIPHERAL_IRQ_ENABLE_BIT];
            ien_r.global_irq_enable <=
                avs_writedata_in[ncoos_pkg::IEN_GIE_BIT];
        end
    end

    // Increment, written per byte lane
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            inc_r <= ncoos_pkg::RST_WORD;
        end else if (wr_go & (avs_address_in == ncoos_pkg::INC_OFS)) begin
            if (avs_byteenable_in[0]) begin
                inc_r[7:0] <= avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1]) begin
                inc_r[15:8] <= avs_writedata_in[15:8];
            end
            if (avs_byteenable_in[2]) begin
                inc_r[19:16] <= avs_writedata_in[19:16];
            end
        end
    end

    // ---------------------------------------------------------------
    // Accumulator
    // ---------------------------------------------------------------
    // Carry out of the 20-bit add is the overflow strobe.
    // Everything runs on clock_in, so sleep of the system
    // clock does not stop it.
    assign sum   = {1'b0, acc_r} + {1'b0, inc_r};
    assign carry = cfg_r.module_enable & sum[20];

    // Adds on every input clock while enabled
    // Disabled, it holds, so a re-enable resumes the same phase
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            acc_r <= ncoos_pkg::RST_WORD;
        end else if (wr_go & (avs_address_in == ncoos_pkg::ACC_OFS)) begin
            // Software write wins over the add
            acc_r <= avs_writedata_in[19:0];
        end else if (cfg_r.module_enable) begin
            acc_r <= sum[19:0];
        end
    end

    // ---------------------------------------------------------------
    // Output shaping
    // ---------------------------------------------------------------
    // Width 2^n periods: counter loads 2^n - 1
    assign width_m1 = 7'((8'h01 << cfg_r.pulse_width_select) - 8'h01);

    // Next raw level from mode and overflow
    always_comb begin
        raw_nxt = raw_r;
        if (!cfg_r.module_enable) begin
            // Disabled stage idles inactive
            raw_nxt = 1'b0;
        end else if (cfg_r.pulse_mode_select) begin
            if (carry) begin
                raw_nxt = 1'b1;
            end else if (cnt_r == 7'h00) begin
                raw_nxt = 1'b0;
            end
        end else if (carry) begin
            raw_nxt = ~raw_r;
        end
    end

    // Raw level flop
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            raw_r <= 1'b0;
        end else begin
            raw_r <= raw_nxt;
        end
    end

    // Pulse counter; an overflow mid-pulse reloads it so the
    // output stays held rather than toggling
    // It also counts down while disabled, so a stale count dies out
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= 7'h00;
        end else if (carry & cfg_r.pulse_mode_select) begin
            cnt_r <= width_m1;
        end else if (cnt_r != 7'h00) begin
            cnt_r <= cnt_r - 7'h01;
        end
    end

    // ---------------------------------------------------------------
    // Polarity stage
    // ---------------------------------------------------------------
    // Polarity after this cycle's write, so level follows at once
    // Using the new value saves a cycle of lag on a polarity change
    assign pol_wr  = wr_go & avs_byteenable_in[0] &
                     (avs_address_in == ncoos_pkg::CTRL_OFS);
    assign pol_nxt = pol_wr ? avs_writedata_in[ncoos_pkg::CTRL_POL_BIT]
                            : cfg_r.output_polarity;
    assign pol_flip = pol_wr & (pol_nxt != cfg_r.output_polarity);

    // Final level is a flop, inverted last
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            level_r <= 1'b0;
        end else begin
            level_r <= raw_nxt ^ pol_nxt;
        end
    end
    assign nco_out = level_r;

    // ---------------------------------------------------------------
    // Interrupt flag
    // ---------------------------------------------------------------
    // Writing zero to the flag bit clears it; a set in the same
    // cycle wins so no overflow is lost.
    assign flag_clr = wr_go & avs_byteenable_in[0] &
                      (avs_address_in == ncoos_pkg::IREQ_OFS) &
                      ~avs_writedata_in[ncoos_pkg::IREQ_FLAG_BIT];

    // Sticky flag
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            flag_r <= 1'b0;
        end else if (carry) begin
            flag_r <= 1'b1;
        end else if (pol_flip & ien_r.overflow_irq_enable) begin
            flag_r <= 1'b1;
        end else if (flag_clr) begin
            flag_r <= 1'b0;
        end
    end

    // Delivered only with all four enables
    // An overflow still sets the flag with the three irq enables off; only delivery is gated
    assign overflow_interrupt_out = flag_r & cfg_r.module_enable &
                                    ien_r.overflow_irq_enable &
                                    ien_r.peripheral_irq_enable &
                                    ien_r.global_irq_enable;

    // ---------------------------------------------------------------
    // Clock source hooks
    // ---------------------------------------------------------------
    // Fast oscillator must stay alive through sleep when it feeds us
    assign clock_select_out  = cfg_r.clock_select;
    assign keep_fast_osc_out = cfg_r.module_enable &
        (cfg_r.clock_select == ncoos_pkg::CKS_FAST_OSC);
endmodule
`default_nettype wire

// *** verif/ncoos_assertions.sv ***
`default_nettype none
// ---------------------------------------------------------------
// Port checker; mirrors register writes to know the cause of outputs
// ---------------------------------------------------------------
module ncoos_assertions (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic [4:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        nco_out,
    input wire logic        overflow_interrupt_out,
    input wire logic [1:0]  clock_select_out,
    input wire logic        keep_fast_osc_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       wr_ok;  // Accepted write on lane 0
    logic [2:0] ctrl_r; // Enable, polarity, pulse mode
    logic [4:0] clkc_r; // Width code, clock select
    logic [2:0] ien_r;  // Gie, peripheral_irq_enable, ie
    logic [7:0] hi_r;   // High samples so far; saturates, reloads can run long
    assign wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    // Shadow copies update at the accept edge, like the real registers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= 3'h0;
            clkc_r <= 5'h00;
            ien_r  <= 3'h0;
        end else if (wr_ok) begin
            if (avs_address_in == ncoos_pkg::CTRL_OFS) begin
                ctrl_r <= {avs_writedata_in[7], avs_writedata_in[4], avs_writedata_in[0]};
            end
            if (avs_address_in == ncoos_pkg::CLKC_OFS) begin
                clkc_r <= {avs_writedata_in[7:5], avs_writedata_in[1:0]};
            end
            if (avs_address_in == ncoos_pkg::IEN_OFS) begin
                ien_r <= avs_writedata_in[2:0];
            end
        end
    end
    // Run-length counter of the output
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            hi_r <= 8'h00;
        end else begin
            hi_r <= !nco_out ? 8'h00 : (hi_r == 8'hff ? hi_r : hi_r + 8'h01);
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence s_req_first;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_pulse_end;
        ctrl_r[2] && $past(ctrl_r[2]) && ctrl_r[0] && !ctrl_r[1] && $fell(nco_out);
    endsequence
    a_bus_one_wait: assert property (s_req_first |=> !avs_waitrequest_out)
        else $error("bus answer late");
    a_pulse_min_width: assert property (
        s_pulse_end |-> hi_r >= (8'h01 << clkc_r[4:2]))
        else $error("pulse shorter than code");
    a_idle_level: assert property (
        !ctrl_r[2] && $past(ctrl_r[2]) == 1'b0 |-> nco_out == ctrl_r[1])
        else $error("idle level not polarity");
    a_irq_gate_all: assert property (
        overflow_interrupt_out |-> ctrl_r[2] && ien_r == 3'h7)
        else $error("interrupt without all enables");
    a_irq_flag_held: assert property (
        overflow_interrupt_out && !avs_write_in |=> overflow_interrupt_out)
        else $error("interrupt dropped by itself");
    a_fast_osc_keep: assert property (
        keep_fast_osc_out == (ctrl_r[2] && clkc_r[1:0] == ncoos_pkg::CKS_FAST_OSC))
        else $error("fast oscillator request wrong");
    a_clock_select: assert property (clock_select_out == clkc_r[1:0])
        else $error("clock select wrong");
    a_ctrl_unused_zero: assert property (
        avs_read_in && !avs_waitrequest_out && avs_address_in == ncoos_pkg::CTRL_OFS
        |-> avs_readdata_out[6] == 1'b0 && avs_readdata_out[3:1] == 3'h0)
        else $error("unused control bits not zero");
    a_reset_clear: assert property (
        $fell(rst_in) |-> !nco_out && !overflow_interrupt_out && !keep_fast_osc_out)
        else $error("outputs not clear after reset");
endmodule
bind ncoos_top ncoos_assertions u_ncoos_assertions (
    .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .nco_out(nco_out), .overflow_interrupt_out(overflow_interrupt_out),
    .clock_select_out(clock_select_out), .keep_fast_osc_out(keep_fast_osc_out));
`default_nettype wire

// *** verif/ncoos_sink.sv ***
`default_nettype none
// ---------------------------------------------------------------
// Far-side model: a peripheral that counts edges of the stage output
// ---------------------------------------------------------------
module ncoos_sink (
    input  wire logic clock_in,     // Same input clock as the stage
    input  wire logic rst_in,       // Async reset, high
    input  wire logic level_in,     // Stage output as seen by the user
    output var  int   rise_cnt_out, // Rising edges seen
    output var  int   fall_cnt_out, // Falling edges seen
    output var  int   last_high_out // Length of the last full high run
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prev_r; // Level at the previous edge
    int   run_r;  // High samples in the current run
    // Sample on the input clock, as a synchronous consumer would
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            prev_r        <= 1'b0;
            run_r         <= 0;
            rise_cnt_out  <= 0;
            fall_cnt_out  <= 0;
            last_high_out <= 0;
        end else begin
            prev_r <= level_in;
            run_r  <= level_in ? run_r + 1 : 0;
            if (level_in && !prev_r) begin // Run starts
                rise_cnt_out <= rise_cnt_out + 1;
            end
            if (!level_in && prev_r) begin // Run ends: keep its length
                fall_cnt_out  <= fall_cnt_out + 1;
                last_high_out <= run_r;
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/ncoos_top_tb.sv ***
`default_nettype none
// ---------------------------------------------------------------
// Bench: register bus master, far-side counter, scenarios
// ---------------------------------------------------------------
module ncoos_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock_in = 1'b0; // 200 MHz
    logic        rst_in   = 1'b1; // Held at start
    logic [4:0]  adr      = 5'h00;
    logic        rd       = 1'b0;
    logic        wr       = 1'b0;
    logic [31:0] wd       = 32'h0;
    logic [3:0]  be       = 4'hf; // All lanes; 8-bit registers use lane 0
    logic [31:0] rdata, rv;       // Bus read data, last value taken
    logic        wreq, nout, irq, keep;
    logic [1:0]  csel;
    int          rise, fall, hlen, f;
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;
    always #2.5 clock_in = ~clock_in;
    ncoos_top u_ncoos_top (.clock_in(clock_in), .rst_in(rst_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .nco_out(nout), .overflow_interrupt_out(irq), .clock_select_out(csel),
        .keep_fast_osc_out(keep));
    ncoos_sink u_ncoos_sink (.clock_in(clock_in), .rst_in(rst_in), .level_in(nout),
        .rise_cnt_out(rise), .fall_cnt_out(fall), .last_high_out(hlen));
    // Verdict; reached from the main sequence or the watchdog
    task end_sim;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus access; waitrequest and read data are taken at the same rising edge
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock_in);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        @(posedge clock_in);
        while (wreq) begin
            @(posedge clock_in);
        end
        rv = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge clock_in); // Let the accept edge settle before any check
    endtask
    task wait_fall(input int n);
        int t;
        t = fall + n;
        while (fall < t) @(posedge clock_in);
    endtask
    // Watchdog: whole run needs under 10k cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            end_sim();
        end
    end
    // Every register and an unmapped place read zero
    task t_reset_values;
        logic [4:0] ofs [7];
        ofs = '{ncoos_pkg::CTRL_OFS, ncoos_pkg::CLKC_OFS, ncoos_pkg::INC_OFS,
                ncoos_pkg::ACC_OFS, ncoos_pkg::IREQ_OFS, ncoos_pkg::IEN_OFS, 5'h18};
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0);
            chk(rv, 32'h0);
        end
    endtask
    // Control fields, status bit and polarity on a quiet accumulator
    task t_ctrl_fields;
        bus(1'b1, ncoos_pkg::CTRL_OFS, 32'hff);
        bus(1'b0, ncoos_pkg::CTRL_OFS, 32'h0);
        chk(rv & 32'hdf, 32'h91);
        chk(32'(rv[5]), 32'(nout));
        chk(32'(nout), 32'h1);
        bus(1'b1, ncoos_pkg::CTRL_OFS, 32'h0);
        chk(32'(nout), 32'h0);
    endtask
    // Divide mode: carry every 4 clocks gives 4 high, 4 low
    task t_fdc;
        bus(1'b1, ncoos_pkg::INC_OFS, 32'h40000);
        bus(1'b1, ncoos_pkg::CTRL_OFS, 32'h80);
        wait_fall(3);
        chk(32'(hlen), 32'h4);
        chk(32'(rise), 32'(fall));
        bus(1'b0, ncoos_pkg::IREQ_OFS, 32'h0);
        chk(rv, 32'h1);
        bus(1'b1, ncoos_pkg::CTRL_OFS, 32'h0);
        bus(1'b1, ncoos_pkg::IREQ_OFS, 32'h0);
        bus(1'b0, ncoos_pkg::IREQ_OFS, 32'h0);
        chk(rv, 32'h0);
    endtask
    // Pulse mode, every width code, overflow every 256 clocks
    task t_pfm;
        bus(1'b1, ncoos_pkg::INC_OFS, 32'h1000);
        for (int n = 0; n < 8; n++) begin
            bus(1'b1, ncoos_pkg::CTRL_OFS, 32'h0);
            bus(1'b1, ncoos_pkg::CLKC_OFS, 32'(n) << 5);
            bus(1'b1, ncoos_pkg::CTRL_OFS, 32'h81);
            wait_fall(2);
            chk(32'(hlen), 32'h1 << n);
        end
    endtask
    // Width 128 against overflow every 64: output stays active
    task t_held;
        bus(1'b1, ncoos_pkg::CTRL_OFS, 32'h0);
        bus(1'b1, ncoos_pkg::CLKC_OFS, 32'he0);
        bus(1'b1, ncoos_pkg::INC_OFS, 32'h4000);
        bus(1'b1, ncoos_pkg::CTRL_OFS, 32'h81);
        repeat (200) @(posedge clock_in);
        f = fall;
        repeat (400) @(posedge clock_in);
        chk(32'(fall), 32'(f));
        chk(32'(nout), 32'h1);
    endtask
    // Interrupt gating, then a polarity change raising the flag
    task t_irq;
        bus(1'b1, ncoos_pkg::IEN_OFS, 32'h7);
        chk(32'(irq), 32'h1);
        bus(1'b1, ncoos_pkg::IEN_OFS, 32'h3);
        chk(32'(irq), 32'h0);
        bus(1'b1, ncoos_pkg::CTRL_OFS, 32'h0);
        bus(1'b1, ncoos_pkg::IREQ_OFS, 32'h0);
        bus(1'b1, ncoos_pkg::IEN_OFS, 32'h1);
        bus(1'b1, ncoos_pkg::CTRL_OFS, 32'h10);
        bus(1'b0, ncoos_pkg::IREQ_OFS, 32'h0);
        chk(rv, 32'h1);
    endtask
    // Clock source select and the request to keep the fast oscillator
    task t_clock;
        bus(1'b1, ncoos_pkg::CLKC_OFS, 32'h1);
        chk(32'(csel), 32'h1);
        chk(32'(keep), 32'h0);
        bus(1'b1, ncoos_pkg::CTRL_OFS, 32'h80);
        bus(1'b1, ncoos_pkg::CLKC_OFS, 32'h0);
        chk(32'(keep), 32'h1);
    endtask
    // Reset in mid-run while the stage toggles: everything clears again
    task t_mid_reset;
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        t_reset_values();
        chk(32'({nout, irq, keep, csel}), 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        t_reset_values();
        t_ctrl_fields();
        t_fdc();
        t_pfm();
        t_held();
        t_irq();
        t_clock();
        t_mid_reset();
        end_sim();
    end
endmodule
`default_nettype wire
